// *** rtl/pattern_seq_map.vh ***
// register map, field positions and encodings of the alternate pattern sequencer
`ifndef PATTERN_SEQ_MAP_VH
`define PATTERN_SEQ_MAP_VH
`define OFS_CTRL        12'h000
`define OFS_LENGTH      12'h004
`define OFS_MEM_ADDR    12'h008
`define OFS_MEM_DATA    12'h00C
`define OFS_CMD         12'h010
`define OFS_STATUS      12'h014
`define CTRL_RESET      32'h0000_0000
`define CTRL_TYPE_BIT   0
`define CTRL_SRC_BIT    1
`define CTRL_MODE_LSB   2
`define CTRL_SEL_LSB    4
`define CTRL_EN_BIT     6
`define TYPE_WHOLE      1'b0
`define TYPE_TWO_HALF   1'b1
`define SRC_INTERNAL    1'b0
`define SRC_EXTERNAL    1'b1
`define MODE_ALTERNATE  2'h0
`define MODE_SINGLE     2'h1
`define MODE_LEVEL      2'h2
`define MODE_EDGE       2'h3
`define SEL_FIRST       2'h0
`define SEL_SECOND      2'h1
`define SEL_BOTH        2'h2
`define CMD_INSERT_BIT  0
`define MEM_AW          10
`define MEM_DEPTH       1024
`define LEN_RESET       11'h010
`endif

// *** rtl/pattern_mem.v ***
// single-port-write, registered-read pattern memory, one bit per word
`timescale 1ns/1ps
`include "pattern_seq_map.vh"
module pattern_mem (
   // clock
   input  wire                  pclk,
   // write side
   input  wire                  wr_en,
   input  wire [`MEM_AW-1:0]    wr_addr,
   input  wire                  wr_bit,
   // read side
   input  wire [`MEM_AW-1:0]    rd_addr,
   output reg                   rd_bit
);
   reg mem [0:`MEM_DEPTH-1];
   always @(posedge pclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_bit;
      end
      rd_bit <= mem[rd_addr];
   end
endmodule

// *** rtl/alt_pattern_seq.v ***
// alternate pattern sequencer: apb registers, half selection and serial output
//
// Behaviour
// - whole type repeats entire pattern continuously
// - two-half type splits pattern into A, B
// - source picks internal command or aux input
// - external alternate/level: aux high B, low A
// - internal alternate/level: select A, B, alternating
// - external single/edge: rising edge inserts one B
// - internal single: insert command inserts one B
// - internal edge mode unsupported, invalid flagged
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "pattern_seq_map.vh"
module alt_pattern_seq (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // pattern link
   input  wire        aux_in,
   output reg         pattern_out,
   output reg         half_change_trig,
   output reg         pattern_start_trig
);
   localparam ST_IDLE = 2'h0;
   localparam ST_A    = 2'h1;
   localparam ST_B    = 2'h2;

   reg [31:0]         ctrl_q;
   reg [`MEM_AW:0]    len_q;
   reg [`MEM_AW-1:0]  maddr_q;
   reg                ins_pend_q;
   reg [1:0]          state_q;
   reg [`MEM_AW-1:0]  pos_q;
   reg                aux_s1_q;
   reg                aux_s2_q;
   reg                aux_s3_q;
   reg                edge_pend_q;
   reg                alt_next_b_q;
   reg                out_valid_q;
   reg                cur_b_q;
   wire [`MEM_AW-1:0] rd_bit_addr;
   wire               rd_bit;

   wire       two_half = ctrl_q[`CTRL_TYPE_BIT];
   wire       src_ext  = ctrl_q[`CTRL_SRC_BIT];
   wire [1:0] mode     = ctrl_q[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
   wire [1:0] sel      = ctrl_q[`CTRL_SEL_LSB+1:`CTRL_SEL_LSB];
   wire       run      = ctrl_q[`CTRL_EN_BIT];
   // internal edge mode gives no defined output
   wire       invalid  = two_half && !src_ext && (mode == `MODE_EDGE);
   wire       setup    = psel && !penable;
   wire       wr_acc   = psel && penable && pwrite;
   wire       wr_data  = wr_acc && (paddr == `OFS_MEM_DATA);
   wire       wr_cmd   = wr_acc && (paddr == `OFS_CMD) && pwdata[`CMD_INSERT_BIT];
   wire       aux_rise = aux_s2_q && !aux_s3_q;
   wire [`MEM_AW-1:0] half_len = len_q[`MEM_AW:1];
   wire       in_a     = (state_q == ST_A);
   // requests only count in their own insert mode, so none is left over for later
   wire       cmd_ins  = wr_cmd && two_half && !src_ext && (mode == `MODE_SINGLE);
   wire       ext_ins  = aux_rise && two_half && src_ext &&
                         (mode == `MODE_SINGLE || mode == `MODE_EDGE);
   wire       last_bit;

   function [`MEM_AW-1:0] half_end;
      input              th;
      input [`MEM_AW:0]  l;
      begin
         if (th) begin
            half_end = l[`MEM_AW:1] - 1'b1;
         end else begin
            half_end = l[`MEM_AW-1:0] - 1'b1;
         end
      end
   endfunction

   function known_reg;
      input [11:0] a;
      begin
         known_reg = (a == `OFS_CTRL) || (a == `OFS_LENGTH) ||
                     (a == `OFS_MEM_ADDR) || (a == `OFS_MEM_DATA) ||
                     (a == `OFS_CMD) || (a == `OFS_STATUS);
      end
   endfunction

   assign last_bit = (state_q == ST_A || state_q == ST_B) &&
                     (pos_q == half_end(two_half, len_q));

   // decide the half to send next, sampled only at a half boundary
   reg next_b;
   always @* begin
      next_b = 1'b0;
      if (two_half) begin
         if (src_ext) begin
            if (mode == `MODE_ALTERNATE || mode == `MODE_LEVEL) begin
               next_b = aux_s2_q;
            end else begin
               // an inserted half always returns to A afterwards
               next_b = in_a && (edge_pend_q || aux_rise);
            end
         end else begin
            case (mode)
               `MODE_ALTERNATE, `MODE_LEVEL: begin
                  case (sel)
                     `SEL_FIRST:  next_b = 1'b0;
                     `SEL_SECOND: next_b = 1'b1;
                     `SEL_BOTH:   next_b = alt_next_b_q;
                     default:     next_b = 1'b0;
                  endcase
               end
               `MODE_SINGLE: next_b = in_a && (ins_pend_q || wr_cmd);
               default:      next_b = 1'b0;
            endcase
         end
      end
   end

   // apb slave, answers with zero wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q  <= `CTRL_RESET;
         len_q   <= `LEN_RESET;
         maddr_q <= {`MEM_AW{1'b0}};
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup && !known_reg(paddr);
         if (setup && !pwrite) begin
            case (paddr)
               `OFS_CTRL:     prdata <= {25'h0, ctrl_q[6:0]};
               `OFS_LENGTH:   prdata <= {21'h0, len_q};
               `OFS_MEM_ADDR: prdata <= {22'h0, maddr_q};
               `OFS_STATUS:   prdata <= {27'h0, invalid, ins_pend_q || edge_pend_q,
                                         cur_b_q, state_q};
               default:       prdata <= 32'h0000_0000;
            endcase
         end
         if (wr_acc && paddr == `OFS_CTRL) begin
            ctrl_q <= {25'h0, pwdata[6:0]};
         end
         if (wr_acc && paddr == `OFS_LENGTH) begin
            // zero length would wrap only after 1024 bits, so clamp to one bit per half
            len_q <= (pwdata[`MEM_AW:0] < 11'h002) ? 11'h002 : pwdata[`MEM_AW:0];
         end
         if (wr_acc && paddr == `OFS_MEM_ADDR) begin
            maddr_q <= pwdata[`MEM_AW-1:0];
         end else if (wr_data) begin
            maddr_q <= maddr_q + 1'b1;
         end
      end
   end

   pattern_mem u_mem (
      .pclk    (pclk),
      .wr_en   (wr_data),
      .wr_addr (maddr_q),
      .wr_bit  (pwdata[0]),
      .rd_addr (rd_bit_addr),
      .rd_bit  (rd_bit)
   );

   assign rd_bit_addr = (state_q == ST_B) ? (pos_q + half_len) : pos_q;

   // sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q            <= ST_IDLE;
         pos_q              <= {`MEM_AW{1'b0}};
         aux_s1_q           <= 1'b0;
         aux_s2_q           <= 1'b0;
         aux_s3_q           <= 1'b0;
         edge_pend_q        <= 1'b0;
         ins_pend_q         <= 1'b0;
         alt_next_b_q       <= 1'b0;
         out_valid_q        <= 1'b0;
         cur_b_q            <= 1'b0;
         pattern_out        <= 1'b0;
         half_change_trig   <= 1'b0;
         pattern_start_trig <= 1'b0;
      end else begin
         aux_s1_q    <= aux_in;
         aux_s2_q    <= aux_s1_q;
         aux_s3_q    <= aux_s2_q;
         out_valid_q <= (state_q != ST_IDLE) && !invalid;
         pattern_out <= out_valid_q ? rd_bit : 1'b0;
         half_change_trig   <= 1'b0;
         pattern_start_trig <= 1'b0;
         // a boundary takes one request; a second one in that cycle stays pending
         if (last_bit && next_b && in_a) begin
            edge_pend_q <= edge_pend_q && ext_ins;
            ins_pend_q  <= ins_pend_q && cmd_ins;
         end else begin
            if (ext_ins) begin
               edge_pend_q <= 1'b1;
            end
            if (cmd_ins) begin
               ins_pend_q <= 1'b1;
            end
         end
         case (state_q)
            ST_IDLE: begin
               if (run && !invalid) begin
                  state_q            <= ST_A;
                  pos_q              <= {`MEM_AW{1'b0}};
                  cur_b_q            <= 1'b0;
                  pattern_start_trig <= 1'b1;
               end
            end
            ST_A, ST_B: begin
               if (!run || invalid) begin
                  state_q <= ST_IDLE;
               end else if (last_bit) begin
                  pos_q <= {`MEM_AW{1'b0}};
                  if (!two_half) begin
                     state_q            <= ST_A;
                     pattern_start_trig <= 1'b1;
                  end else begin
                     state_q            <= next_b ? ST_B : ST_A;
                     cur_b_q            <= next_b;
                     alt_next_b_q       <= ~next_b;
                     half_change_trig   <= next_b != (state_q == ST_B);
                     pattern_start_trig <= !next_b;
                  end
               end else begin
                  pos_q <= pos_q + 1'b1;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule

// *** dv/alt_pattern_seq_checker.sv ***
// protocol and stream assertions for the alternate pattern sequencer
`timescale 1ns/1ps
module alt_pattern_seq_checker (
   // clock and reset
   input wire        pclk,
   input wire        presetn,
   // apb
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // pattern
   input wire        pattern_out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s; psel && !penable; endsequence
   sequence access_s; psel && penable; endsequence
   first_access_a: assert property (setup_s ##1 access_s |-> pready)
      else $error("ready missing in first access cycle");
   ready_once_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   ready_phase_a: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   unmapped_err_a: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
      else $error("unmapped access accepted");
   ctrl_ok_a: assert property (psel && penable && paddr == 12'h000 |-> !pslverr)
      else $error("control access refused");
   err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   // first edge out of reset must still show reset values
   reset_quiet_a: assert property ($rose(presetn) |-> !pattern_out && !pready)
      else $error("outputs active after reset");
endmodule
bind alt_pattern_seq alt_pattern_seq_checker alt_pattern_seq_checker_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pattern_out(pattern_out)
);

// *** dv/link_partner.sv ***
// far side: aux input source and a sink counting low pattern bits
`timescale 1ns/1ps
module link_partner (
   // clock
   input wire        pclk,
   // bench control
   input wire        aux_level,
   input wire        clear,
   // link
   input wire        pattern_out,
   output reg        aux_in = 1'b0,
   output reg [31:0] lows = 32'h0
);
   always @(posedge pclk) begin
      aux_in <= aux_level;
      lows   <= clear ? 32'h0 : lows + {31'h0, !pattern_out};
   end
endmodule

// *** dv/alt_pattern_seq_bench.sv ***
// self-checking bench for the alternate pattern sequencer
`timescale 1ns/1ps
`include "pattern_seq_map.vh"
module alt_pattern_seq_bench;
   reg         pclk = 1'b0;
   reg         presetn = 1'b0;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h0;
   reg         aux_level = 1'b0;
   reg         clear = 1'b0;
   reg  [31:0] rdata;
   reg         rerr;
   wire [31:0] prdata;
   wire        pready;
   wire        pslverr;
   wire        aux_in;
   wire        pattern_out;
   wire [31:0] lows;
   wire        half_change_trig;
   wire        pattern_start_trig;
   int         n_errors = 0;
   int         n_compared = 0;
   int         cycles = 0;
   int         starts = 0;
   int         changes = 0;
   // control words: run, select, mode, source, type; half A all ones, B all zeros
   logic [7:0] mix [7] = '{8'h41, 8'h51, 8'h61, 8'h49, 8'h43, 8'h4B, 8'h4B};
   logic [5:0] want [7] = '{0, 32, 16, 0, 32, 0, 32};
   logic       aux_of [7] = '{0, 0, 0, 0, 1, 0, 1};
   logic [7:0] ins [3] = '{8'h45, 8'h47, 8'h4F};
   always #50 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors++;
         stop_test;
      end
   end
   // pulse tallies share the window of the low-bit sink
   always @(posedge pclk) begin
      starts  <= clear ? 0 : starts + pattern_start_trig;
      changes <= clear ? 0 : changes + half_change_trig;
   end
   alt_pattern_seq alt_pattern_seq_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .aux_in(aux_in),
      .pattern_out(pattern_out), .half_change_trig(half_change_trig),
      .pattern_start_trig(pattern_start_trig));
   link_partner link_partner_i (.pclk(pclk), .aux_level(aux_level), .clear(clear),
      .pattern_out(pattern_out), .aux_in(aux_in), .lows(lows));
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      rerr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // type first, then length, then both halves of data
   task automatic load(input logic t);
      int i;
      xfer(1'b1, `OFS_CTRL, {31'h0, t});
      xfer(1'b1, `OFS_LENGTH, 32'h10);
      xfer(1'b1, `OFS_MEM_ADDR, 32'h0);
      for (i = 0; i < 16; i++) xfer(1'b1, `OFS_MEM_DATA, {31'h0, i < 8});
   endtask
   task automatic mark;
      @(posedge pclk);
      clear <= 1'b1;
      @(posedge pclk);
      clear <= 1'b0;
   endtask
   task automatic tally(input int n, output logic [31:0] got);
      // one edge more: read the tally before that edge updates it
      repeat (n + 1) @(posedge pclk);
      got = lows;
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      logic [31:0] got;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      xfer(1'b0, `OFS_CTRL, 32'h0);
      check("ctrl reset", `CTRL_RESET, rdata);
      xfer(1'b0, `OFS_LENGTH, 32'h0);
      check("length reset", {21'h0, `LEN_RESET}, rdata);
      xfer(1'b1, `OFS_LENGTH, 32'h1);
      xfer(1'b0, `OFS_LENGTH, 32'h0);
      check("length clamp", 32'h2, rdata);
      xfer(1'b1, 12'h018, 32'hFFFF_FFFF);
      check("unmapped write", 32'h1, {31'h0, rerr});
      xfer(1'b0, 12'h018, 32'h0);
      check("unmapped read", 32'h0, rdata);
      $display("test registers done");
      load(`TYPE_WHOLE);
      xfer(1'b1, `OFS_CTRL, 32'h40);
      repeat (40) @(posedge pclk);
      mark;
      tally(32, got);
      check("whole lows", 32'h10, got);
      check("whole starts", 32'h2, starts);
      $display("test whole done");
      load(`TYPE_TWO_HALF);
      foreach (mix[k]) begin
         aux_level <= aux_of[k];
         xfer(1'b1, `OFS_CTRL, {24'h0, mix[k]});
         repeat (40) @(posedge pclk);
         mark;
         tally(32, got);
         check("half lows", {26'h0, want[k]}, got);
         check("half changes", (k == 2) ? 32'h4 : 32'h0, changes);
      end
      $display("test halves done");
      foreach (ins[k]) begin
         aux_level <= 1'b0;
         xfer(1'b1, `OFS_CTRL, {24'h0, ins[k]});
         repeat (40) @(posedge pclk);
         mark;
         if (k == 0) xfer(1'b1, `OFS_CMD, 32'h1);
         else aux_level <= 1'b1;
         repeat (30) @(posedge pclk);
         aux_level <= 1'b0;
         tally(30, got);
         check("insert lows", 32'h8, got);
         check("insert changes", 32'h2, changes);
      end
      $display("test insert done");
      xfer(1'b1, `OFS_CTRL, 32'h4D);
      repeat (20) @(posedge pclk);
      xfer(1'b0, `OFS_STATUS, 32'h0);
      check("invalid flag", 32'h1, {31'h0, rdata[4]});
      mark;
      tally(32, got);
      check("invalid lows", 32'h20, got);
      $display("test invalid done");
      stop_test;
   end
endmodule
